// ==== core/cad_pkg.sv ====
/*
 * cad_pkg: opcode patterns, sub-operation codes, clock counts and the
 * decoded-instruction carrier shared by the decoder and its helpers.
 * Assumes one core clock; counts are in core clocks.
 */
package cad_pkg;

	// primary opcodes
	localparam logic [7:0] OP_ESCAPE      = 8'h0f;
	localparam logic [7:0] OP_OUT_FIXED   = 8'he6;   // low bit is w
	localparam logic [7:0] OP_OUT_VAR     = 8'hee;
	localparam logic [7:0] OP_EA_LOAD     = 8'h8d;
	localparam logic [7:0] OP_FAR_DS      = 8'hc5;
	localparam logic [7:0] OP_FAR_ES      = 8'hc4;
	localparam logic [7:0] OP_CARRY_INV   = 8'hf5;
	localparam logic [7:0] OP_FLAGS_TO_HB = 8'h9f;
	localparam logic [7:0] OP_HB_TO_FLAGS = 8'h9e;
	localparam logic [7:0] OP_CLR_CARRY   = 8'hf8;
	localparam logic [7:0] OP_SET_CARRY   = 8'hf9;
	localparam logic [7:0] OP_CLR_DIR     = 8'hfc;
	localparam logic [7:0] OP_SET_DIR     = 8'hfd;
	localparam logic [7:0] OP_INT_CLR     = 8'hfa;
	localparam logic [7:0] OP_INT_SET     = 8'hfb;
	localparam logic [7:0] OP_BYTE_EXT    = 8'h98;
	localparam logic [7:0] OP_WORD_EXT    = 8'h99;
	localparam logic [7:0] OP_UNP_SUB_ADJ = 8'h3f;
	localparam logic [7:0] OP_PK_ADD_ADJ  = 8'h27;
	localparam logic [7:0] OP_PK_SUB_ADJ  = 8'h2f;
	localparam logic [7:0] OP_ADJ_DIV     = 8'hd5;
	localparam logic [7:0] OP_ADJ_MUL     = 8'hd4;
	localparam logic [7:0] OP_ADJ_BASE    = 8'h0a;
	localparam logic [7:0] OP_TEST_ACC    = 8'ha8;
	localparam logic [7:0] OP_TEST_RM     = 8'h84;
	localparam logic [7:0] OP_UNARY_GRP   = 8'hf6;
	localparam logic [5:0] OP_IMM_ARITH   = 6'h20;   // 100000sw
	localparam logic [7:0] OP_SHIFT_1     = 8'hd0;
	localparam logic [7:0] OP_SHIFT_CNT   = 8'hd2;
	localparam logic [7:0] OP_SHIFT_IMM   = 8'hc0;
	// second bytes after the escape
	localparam logic [7:0] OP2_TASK_CLR   = 8'h06;
	localparam logic [7:0] OP2_FAR_SS     = 8'hb2;
	localparam logic [7:0] OP2_FAR_FS     = 8'hb4;
	localparam logic [7:0] OP2_FAR_GS     = 8'hb5;
	localparam logic [7:0] OP2_DBL_L_IMM  = 8'ha4;
	localparam logic [7:0] OP2_DBL_L_CNT  = 8'ha5;
	localparam logic [7:0] OP2_DBL_R_IMM  = 8'hac;
	localparam logic [7:0] OP2_DBL_R_CNT  = 8'had;

	// shift_op_field encodings
	localparam logic [2:0] SH_ROT_L   = 3'h0;
	localparam logic [2:0] SH_ROT_R   = 3'h1;
	localparam logic [2:0] SH_ROT_LC  = 3'h2;
	localparam logic [2:0] SH_ROT_RC  = 3'h3;
	localparam logic [2:0] SH_LEFT    = 3'h4;
	localparam logic [2:0] SH_LOG_R   = 3'h5;
	localparam logic [2:0] SH_ARITH_R = 3'h7;
	// immediate arithmetic reg field
	localparam logic [2:0] AR_ADD = 3'h0;
	localparam logic [2:0] AR_ADC = 3'h2;
	localparam logic [2:0] AR_SBB = 3'h3;
	localparam logic [2:0] AR_SUB = 3'h5;
	localparam logic [2:0] AR_CMP = 3'h7;
	// unary group reg field
	localparam logic [2:0] UN_TEST = 3'h0;
	localparam logic [2:0] UN_UDIV = 3'h6;
	localparam logic [2:0] UN_SDIV = 3'h7;
	localparam logic [1:0] MOD_REG = 2'h3;

	// clock counts
	localparam logic [5:0] CK_2 = 6'd2;
	localparam logic [5:0] CK_3 = 6'd3;
	localparam logic [5:0] CK_4 = 6'd4;
	localparam logic [5:0] CK_5 = 6'd5;
	localparam logic [5:0] CK_6 = 6'd6;
	localparam logic [5:0] CK_7 = 6'd7;
	localparam logic [5:0] CK_8 = 6'd8;
	localparam logic [5:0] CK_RC_REG  = 6'd9;
	localparam logic [5:0] CK_RC_MEM  = 6'd10;
	localparam logic [5:0] CK_OUT_REAL   = 6'd10;
	localparam logic [5:0] CK_OUT_PRV_OK = 6'd4;
	localparam logic [5:0] CK_OUT_PRV_NO = 6'd24;
	localparam logic [5:0] CK_FAR_PROT_REG = 6'd26;
	localparam logic [5:0] CK_FAR_PROT_MEM = 6'd28;
	localparam logic [5:0] CK_ADJ_DIV = 6'd19;
	localparam logic [5:0] CK_ADJ_MUL = 6'd17;
	localparam logic [5:0] CK_UDIV_B_R = 6'd14;
	localparam logic [5:0] CK_UDIV_B_M = 6'd17;
	localparam logic [5:0] CK_UDIV_W_R = 6'd22;
	localparam logic [5:0] CK_UDIV_W_M = 6'd25;
	localparam logic [5:0] CK_UDIV_D_R = 6'd38;
	localparam logic [5:0] CK_UDIV_D_M = 6'd43;
	localparam logic [5:0] CK_SDIV_B_R = 6'd19;
	localparam logic [5:0] CK_SDIV_B_M = 6'd22;
	localparam logic [5:0] CK_SDIV_W_R = 6'd27;
	localparam logic [5:0] CK_SDIV_W_M = 6'd30;
	localparam logic [5:0] CK_SDIV_D_R = 6'd43;
	localparam logic [5:0] CK_SDIV_D_M = 6'd48;
	localparam logic [5:0] CK_ILLEGAL  = 6'd1;

	// operation classes
	typedef enum logic [4:0] {
		CL_NONE     = 5'b00000,
		CL_OUT      = 5'b00001,
		CL_EA       = 5'b00010,
		CL_FAR      = 5'b00011,
		CL_FLAG     = 5'b00100,
		CL_PRIV     = 5'b00101,
		CL_ARITH    = 5'b00110,
		CL_UDIV     = 5'b00111,
		CL_SDIV     = 5'b01000,
		CL_ADJ      = 5'b01001,
		CL_EXTEND   = 5'b01010,
		CL_SHIFT    = 5'b01011,
		CL_DSHIFT   = 5'b01100,
		CL_TEST     = 5'b01101,
		CL_LOGIC    = 5'b01110
	} cad_class_type;

	// decoded instruction
	typedef struct packed {
		cad_class_type cls;
		logic [2:0]    sub_op;      // shift_op_field or arithmetic select
		logic          wide;        // w bit
		logic          to_reg;      // d bit: reg field is destination
		logic          sign_imm;    // s bit
		logic          mem_opnd;    // operand is in memory
		logic          has_modrm;
		logic          has_imm8;    // trailing 8-bit count byte
		logic          writes_result;
		logic          priv_fault;  // privilege check failed
	} cad_dec_type;

endpackage

// ==== core/cad_div_time.sv ====
/*
 * cad_div_time: clock count for the accumulator divide family.
 * Assumes operand size and register/memory selection come from the decoder.
 */
`timescale 1ns/1ps
module cad_div_time
(
	input  wire logic       i_signed,
	input  wire logic [1:0] i_size,     // 0 byte, 1 word, 2 doubleword
	input  wire logic       i_mem,
	output logic      [5:0] o_clocks
);
	import cad_pkg::*;

	// table lookup; size 3 never decoded, treated as doubleword
	always_comb
	begin
		case ({i_signed, i_size})
			3'h0: o_clocks = i_mem ? CK_UDIV_B_M : CK_UDIV_B_R;
			3'h1: o_clocks = i_mem ? CK_UDIV_W_M : CK_UDIV_W_R;
			3'h4: o_clocks = i_mem ? CK_SDIV_B_M : CK_SDIV_B_R;
			3'h5: o_clocks = i_mem ? CK_SDIV_W_M : CK_SDIV_W_R;
			3'h2, 3'h3: o_clocks = i_mem ? CK_UDIV_D_M : CK_UDIV_D_R;
			default: o_clocks = i_mem ? CK_SDIV_D_M : CK_SDIV_D_R;
		endcase
	end
endmodule

// ==== core/cad_cycle_counter.sv ====
/*
 * cad_cycle_counter: holds the execution unit busy for a loaded count.
 * Assumes a load only while idle.
 */
`timescale 1ns/1ps
module cad_cycle_counter
(
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_load,
	input  wire logic [5:0] i_count,
	output logic            o_busy,
	output logic            o_done
);
	logic [5:0] remain_q;

	// count down; done pulses on the last busy cycle
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			remain_q <= 6'h00;
		else if (i_load)
			remain_q <= i_count;
		else if (remain_q != 6'h00)
			remain_q <= remain_q - 6'h01;
	end

	assign o_busy = (remain_q != 6'h00);
	assign o_done = (remain_q == 6'h01);
endmodule

// ==== core/cad_decoder.sv ====
/*
 * cad_decoder: decodes one instruction's opcode and mod/reg/rm bytes,
 * classifies it and times it in core clocks, then holds busy that long.
 * Assumes the fetch unit presents bytes 0..2 together with a strobe, and
 * that real/protected mode and privilege levels arrive as plain levels.
 */
`timescale 1ns/1ps
module cad_decoder
(
	input  wire logic            i_core_clk,
	input  wire logic            i_rst_b,
	input  wire logic            i_start,          // one-cycle instruction strobe
	input  wire logic [7:0]      i_byte0,
	input  wire logic [7:0]      i_byte1,
	input  wire logic [7:0]      i_byte2,
	input  wire logic            i_op32,           // full width is 32 bits
	input  wire logic            i_protected,
	input  wire logic [1:0]      i_cur_priv,       // current_privilege_level
	input  wire logic [1:0]      i_io_priv,        // io_privilege_level
	output cad_pkg::cad_dec_type o_dec,
	output logic [5:0]           o_clocks,
	output logic                 o_busy,
	output logic                 o_done,
	output logic                 o_accept
);
	import cad_pkg::*;

	logic        esc;
	logic [7:0]  op;
	logic [7:0]  modrm;
	logic [1:0]  mod_f;
	logic [2:0]  reg_f;
	logic        mem;
	logic        io_ok;
	logic        top_priv;
	cad_dec_type dec;
	logic [5:0]  clk_n;
	logic [5:0]  div_clk;
	logic [1:0]  div_size;
	cad_dec_type dec_q;
	logic [5:0]  clocks_q;
	logic        busy;

	// escape byte shifts the opcode one byte along
	assign esc      = (i_byte0 == OP_ESCAPE);
	assign op       = esc ? i_byte1 : i_byte0;
	assign modrm    = esc ? i_byte2 : i_byte1;
	assign mod_f    = modrm[7:6];
	assign reg_f    = modrm[5:3];
	assign mem      = (mod_f != MOD_REG);
	assign io_ok    = (i_cur_priv <= i_io_priv);
	assign top_priv = (i_cur_priv == 2'h0);
	assign div_size = op[0] ? (i_op32 ? 2'h2 : 2'h1) : 2'h0;

	cad_div_time u_div_time
	(
		.i_signed (reg_f == UN_SDIV),
		.i_size   (div_size),
		.i_mem    (mem),
		.o_clocks (div_clk)
	);

	// classify and time; unknown codes become a one-clock illegal slot
	always_comb
	begin
		dec          = '0;
		dec.cls      = CL_NONE;
		dec.wide     = op[0];
		dec.to_reg   = op[1];
		dec.mem_opnd = mem;
		clk_n        = CK_ILLEGAL;
		if (esc)
		begin
			case (op)
				OP2_TASK_CLR:
				begin
					dec.cls        = CL_PRIV;
					dec.mem_opnd   = 1'b0;
					dec.priv_fault = i_protected && !top_priv;
					clk_n          = CK_5;
				end
				OP2_FAR_SS, OP2_FAR_FS, OP2_FAR_GS:
				begin
					dec.cls           = CL_FAR;
					dec.has_modrm     = 1'b1;
					dec.writes_result = 1'b1;
					clk_n = i_protected ? (mem ? CK_FAR_PROT_MEM : CK_FAR_PROT_REG) : CK_7;
				end
				OP2_DBL_L_IMM, OP2_DBL_R_IMM, OP2_DBL_L_CNT, OP2_DBL_R_CNT:
				begin
					dec.cls           = CL_DSHIFT;
					dec.wide          = 1'b1;
					dec.has_modrm     = 1'b1;
					dec.has_imm8      = !op[0];
					dec.writes_result = 1'b1;
					clk_n = mem ? CK_7 : CK_3;
				end
				default: clk_n = CK_ILLEGAL;
			endcase
		end
		else if (op[7:2] == OP_IMM_ARITH)
		begin
			dec.cls       = (reg_f == AR_ADD || reg_f == AR_ADC || reg_f == AR_SBB ||
			                 reg_f == AR_SUB || reg_f == AR_CMP) ? CL_ARITH : CL_LOGIC;
			dec.sub_op    = reg_f;
			dec.sign_imm  = op[1];
			dec.to_reg    = 1'b0;
			dec.has_modrm = 1'b1;
			dec.writes_result = (reg_f != AR_CMP);
			clk_n = !mem ? CK_2 : (reg_f == AR_CMP ? CK_5 : CK_7);
		end
		else if (op[7:2] == 6'h00 || op[7:2] == 6'h04 || op[7:2] == 6'h06 ||
		         op[7:2] == 6'h0a || op[7:2] == 6'h0e || op[7:2] == 6'h08 ||
		         op[7:2] == 6'h02)
		begin
			// two-operand register/memory forms of the arithmetic family and of logic selects 1 and 4; select 6 is not decoded
			dec.cls           = (op[5:3] == 3'h1 || op[5:3] == 3'h4) ? CL_LOGIC : CL_ARITH;
			dec.sub_op        = op[5:3];
			dec.has_modrm     = 1'b1;
			dec.writes_result = (op[5:3] != AR_CMP);
			clk_n = !mem ? CK_2 : (op[1] ? (op[5:3] == AR_CMP ? CK_6 : CK_6)
			                             : (op[5:3] == AR_CMP ? CK_5 : CK_7));
		end
		else
		begin
			case (op)
				OP_OUT_FIXED, OP_OUT_FIXED | 8'h01:
				begin
					dec.cls      = CL_OUT;
					dec.mem_opnd = 1'b0;
					clk_n = !i_protected ? CK_OUT_REAL
					      : (io_ok ? CK_OUT_PRV_OK : CK_OUT_PRV_NO);
				end
				OP_EA_LOAD:
				begin
					dec.cls           = CL_EA;
					dec.has_modrm     = 1'b1;
					dec.to_reg        = 1'b1;
					dec.mem_opnd      = 1'b0;                    // address only, no read
					dec.writes_result = 1'b1;
					clk_n = CK_2;
				end
				OP_FAR_DS, OP_FAR_ES:
				begin
					dec.cls           = CL_FAR;
					dec.has_modrm     = 1'b1;
					dec.writes_result = 1'b1;
					clk_n = i_protected ? (mem ? CK_FAR_PROT_MEM : CK_FAR_PROT_REG) : CK_7;
				end
				OP_CARRY_INV, OP_CLR_CARRY, OP_SET_CARRY, OP_CLR_DIR, OP_SET_DIR, OP_FLAGS_TO_HB:
				begin
					dec.cls      = CL_FLAG;
					dec.mem_opnd = 1'b0;
					clk_n = CK_2;
				end
				OP_HB_TO_FLAGS:
				begin
					dec.cls      = CL_FLAG;
					dec.mem_opnd = 1'b0;
					clk_n = CK_3;
				end
				OP_INT_CLR, OP_INT_SET:
				begin
					dec.cls        = CL_PRIV;
					dec.mem_opnd   = 1'b0;
					dec.priv_fault = i_protected && !io_ok;
					clk_n = CK_8;
				end
				OP_BYTE_EXT:
				begin
					dec.cls = CL_EXTEND;
					dec.mem_opnd = 1'b0;
					clk_n = CK_3;
				end
				OP_WORD_EXT:
				begin
					dec.cls = CL_EXTEND;
					dec.mem_opnd = 1'b0;
					clk_n = CK_2;
				end
				OP_UNP_SUB_ADJ, OP_PK_ADD_ADJ, OP_PK_SUB_ADJ:
				begin
					dec.cls = CL_ADJ;
					dec.mem_opnd = 1'b0;
					clk_n = CK_4;
				end
				OP_ADJ_DIV, OP_ADJ_MUL:
				begin
					dec.mem_opnd = 1'b0;
					if (i_byte1 == OP_ADJ_BASE)
					begin
						dec.cls = CL_ADJ;
						clk_n = (op == OP_ADJ_DIV) ? CK_ADJ_DIV : CK_ADJ_MUL;
					end
				end
				OP_TEST_ACC, OP_TEST_ACC | 8'h01:
				begin
					dec.cls      = CL_TEST;
					dec.mem_opnd = 1'b0;
					clk_n = CK_2;                                // no result written
				end
				OP_TEST_RM, OP_TEST_RM | 8'h01:
				begin
					dec.cls       = CL_TEST;
					dec.has_modrm = 1'b1;
					clk_n = mem ? CK_5 : CK_2;
				end
				OP_UNARY_GRP, OP_UNARY_GRP | 8'h01:
				begin
					dec.has_modrm = 1'b1;
					dec.sub_op    = reg_f;
					if (reg_f == UN_UDIV || reg_f == UN_SDIV)
					begin
						dec.cls = (reg_f == UN_SDIV) ? CL_SDIV : CL_UDIV;
						clk_n = div_clk;
					end
					else if (reg_f == UN_TEST)
					begin
						dec.cls = CL_TEST;
						clk_n = mem ? CK_5 : CK_2;
					end
				end
				OP_SHIFT_1, OP_SHIFT_1 | 8'h01, OP_SHIFT_CNT, OP_SHIFT_CNT | 8'h01,
				OP_SHIFT_IMM, OP_SHIFT_IMM | 8'h01:
				begin
					dec.has_modrm     = 1'b1;
					dec.has_imm8      = (op[7:1] == OP_SHIFT_IMM[7:1]);
					dec.sub_op        = reg_f;
					dec.writes_result = 1'b1;
					case (reg_f)
						SH_ROT_LC, SH_ROT_RC:
						begin
							dec.cls = CL_SHIFT;
							clk_n = mem ? CK_RC_MEM : CK_RC_REG;
						end
						SH_ROT_L, SH_ROT_R, SH_LEFT, SH_LOG_R, SH_ARITH_R:
						begin
							dec.cls = CL_SHIFT;
							clk_n = mem ? CK_7 : CK_3;
						end
						default: dec.writes_result = 1'b0;
					endcase
				end
				default: clk_n = CK_ILLEGAL;
			endcase
		end
	end

	assign o_accept = i_start && !busy;

	// latch the decode when a new instruction is taken
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			dec_q    <= '0;
			clocks_q <= 6'h00;
		end
		else if (o_accept)
		begin
			dec_q    <= dec;
			clocks_q <= clk_n;
		end
	end

	cad_cycle_counter u_counter
	(
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_load     (o_accept),
		.i_count    (clk_n),
		.o_busy     (busy),
		.o_done     (o_done)
	);

	assign o_dec    = dec_q;
	assign o_clocks = clocks_q;
	assign o_busy   = busy;

	// timing, privilege and no-write checks on the latched decode
	rc_time_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		o_accept && dec.cls == CL_SHIFT && (reg_f == SH_ROT_LC || reg_f == SH_ROT_RC)
		|=> o_clocks == (o_dec.mem_opnd ? 6'd10 : 6'd9))
		else $error("carry rotate count wrong");
	dshift_time_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		o_accept && dec.cls == CL_DSHIFT |=> o_clocks == (o_dec.mem_opnd ? 6'd7 : 6'd3))
		else $error("double shift count wrong");
	udiv_time_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		o_accept && dec.cls == CL_UDIV && !op[0] |=> o_clocks == (o_dec.mem_opnd ? 6'd17 : 6'd14))
		else $error("byte divide count wrong");
	sdiv_time_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		o_accept && dec.cls == CL_SDIV && op[0] && i_op32 |=> o_clocks == (o_dec.mem_opnd ? 6'd48 : 6'd43))
		else $error("signed divide count wrong");
	out_time_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		o_accept && dec.cls == CL_OUT && i_protected && !io_ok |=> o_clocks == 6'd24)
		else $error("port output count wrong");
	priv_fault_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		o_accept && esc && op == OP2_TASK_CLR && i_protected && i_cur_priv != 2'h0 |=> o_dec.priv_fault)
		else $error("task flag clear not refused");
	busy_len_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		o_accept && clk_n == 6'd2 |=> o_busy ##1 o_done ##1 !o_busy)
		else $error("busy length wrong");
	test_nowrite_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		o_accept && dec.cls == CL_TEST |=> !o_dec.writes_result)
		else $error("test writes result");
endmodule

// ==== test/cad_decoder_tb.sv ====
/*
 * tb: self-checking bench for the instruction decoder and timer.
 * Assumes the decoder's own inline assertions guard its internals; this
 * bench checks class, fields, count, busy length and done timing at ports.
 */
`timescale 1ns/1ps
module tb;
	import cad_pkg::*;

	logic        i_core_clk;
	logic        i_rst_b;
	logic        i_start;
	logic [7:0]  i_byte0;
	logic [7:0]  i_byte1;
	logic [7:0]  i_byte2;
	logic        i_op32;
	logic        i_protected;
	logic [1:0]  i_cur_priv;
	logic [1:0]  i_io_priv;
	cad_dec_type o_dec;
	logic [5:0]  o_clocks;
	logic        o_busy;
	logic        o_done;
	logic        o_accept;
	int          error_cnt;
	int          tests_run;
	int          seen_n;
	int          seen_done;
	logic        poke;
	// divide counts by signedness, size, memory operand
	int          div_ck [2][3][2] = '{'{'{14, 17}, '{22, 25}, '{38, 43}}, '{'{19, 22}, '{27, 30}, '{43, 48}}};
	int          ar_sel [5] = '{0, 2, 3, 5, 7};

	cad_decoder cad_decoder_inst
	(
		.i_core_clk  (i_core_clk),
		.i_rst_b     (i_rst_b),
		.i_start     (i_start),
		.i_byte0     (i_byte0),
		.i_byte1     (i_byte1),
		.i_byte2     (i_byte2),
		.i_op32      (i_op32),
		.i_protected (i_protected),
		.i_cur_priv  (i_cur_priv),
		.i_io_priv   (i_io_priv),
		.o_dec       (o_dec),
		.o_clocks    (o_clocks),
		.o_busy      (o_busy),
		.o_done      (o_done),
		.o_accept    (o_accept)
	);

	// 50 ns core clock
	always #25 i_core_clk = ~i_core_clk;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// b holds bytes 0..2, m is {op32, protected, cur priv, io priv}
	// CL_NONE as expected class means the class is not compared
	task automatic op(input logic [23:0] b, input logic [5:0] m, input logic [5:0] ck, input cad_class_type cl);
		{i_byte0, i_byte1, i_byte2} = b;
		{i_op32, i_protected, i_cur_priv, i_io_priv} = m;
		i_start = 1'b1;
		#1;
		check("accept", o_accept, 1);
		@(posedge i_core_clk);
		#1;
		// a held strobe while busy must be ignored
		i_start = poke;
		seen_n = 0;
		seen_done = 0;
		while (o_busy === 1'b1 && seen_n < 64)
		begin
			seen_n++;
			if (o_done === 1'b1)
				seen_done = seen_n;
			if (poke)
				check("refused", o_accept, 0);
			@(posedge i_core_clk);
			#1;
		end
		i_start = 1'b0;
		check("clocks", o_clocks, ck);
		check("busy_len", seen_n, ck);
		check("done_at", seen_done, ck);
		if (cl != CL_NONE)
			check("class", o_dec.cls, cl);
	endtask

	// hang guard, far beyond the fewer than one thousand cycles the sequence needs
	initial
	begin
		#2ms;
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		i_core_clk = 1'b0;
		i_rst_b = 1'b0;
		i_start = 1'b0;
		{i_byte0, i_byte1, i_byte2} = 24'h000000;
		{i_op32, i_protected, i_cur_priv, i_io_priv} = 6'h00;
		poke = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		repeat (12) @(posedge i_core_clk);
		#1;
		check("reset_busy", o_busy, 0);
		check("reset_clocks", o_clocks, 0);
		check("reset_done", o_done, 0);
		check("reset_dec", o_dec, 0);
		i_rst_b = 1'b1;
		// every shift field on a register, carry rotates slower
		for (int t = 0; t < 8; t++)
		begin
			if (t != 6)
			begin
				op({8'hd0, 8'hc0 | 8'(t << 3), 8'h00}, 6'h00, (t == 2 || t == 3) ? 6'd9 : 6'd3, CL_SHIFT);
				check("shift_sel", o_dec.sub_op, t);
				check("no_imm", o_dec.has_imm8, 0);
			end
		end
		op(24'hd0f000, 6'h00, 6'd1, CL_NONE);
		check("unused_field", o_dec.cls, CL_NONE);
		op(24'hd21000, 6'h00, 6'd10, CL_SHIFT);
		op(24'hc01800, 6'h00, 6'd10, CL_SHIFT);
		check("imm_count", o_dec.has_imm8, 1);
		op(24'h0fa4c0, 6'h00, 6'd3, CL_DSHIFT);
		check("dbl_imm", o_dec.has_imm8, 1);
		op(24'h0fa400, 6'h00, 6'd7, CL_DSHIFT);
		// divide family over sign, size and operand place
		for (int s = 0; s < 2; s++)
			for (int z = 0; z < 3; z++)
				for (int k = 0; k < 2; k++)
					op({(z == 0) ? 8'hf6 : 8'hf7, (k == 1 ? 8'h00 : 8'hc0) | 8'((6 + s) << 3), 8'h00},
						(z == 2) ? 6'h20 : 6'h00, 6'(div_ck[s][z][k]), s ? CL_SDIV : CL_UDIV);
		// back-to-back accepts, first one with a strobe held while busy
		poke = 1'b1;
		op(24'hd50a00, 6'h00, 6'd19, CL_ADJ);
		poke = 1'b0;
		op(24'hd40a00, 6'h00, 6'd17, CL_ADJ);
		op(24'hd40a00, 6'h13, 6'd17, CL_ADJ);
		op(24'h980000, 6'h00, 6'd3, CL_EXTEND);
		op(24'h990000, 6'h00, 6'd2, CL_EXTEND);
		op(24'h9f0000, 6'h00, 6'd2, CL_FLAG);
		op(24'h9e0000, 6'h00, 6'd3, CL_FLAG);
		op(24'hf50000, 6'h00, 6'd2, CL_FLAG);
		op(24'hfa0000, 6'h00, 6'd8, CL_PRIV);
		op(24'hfb0000, 6'h1a, 6'd8, CL_PRIV);
		check("int_ok", o_dec.priv_fault, 0);
		op(24'hfa0000, 6'h1e, 6'd8, CL_PRIV);
		check("int_fault", o_dec.priv_fault, 1);
		op(24'h0f0600, 6'h10, 6'd5, CL_PRIV);
		check("tsk_ok", o_dec.priv_fault, 0);
		op(24'h0f0600, 6'h17, 6'd5, CL_PRIV);
		check("tsk_fault", o_dec.priv_fault, 1);
		op(24'h8dc000, 6'h00, 6'd2, CL_EA);
		// a memory-form address load still reads nothing
		op(24'h8d0600, 6'h00, 6'd2, CL_EA);
		check("ea_no_read", o_dec.mem_opnd, 0);
		check("ea_modrm", o_dec.has_modrm, 1);
		check("ea_to_reg", o_dec.to_reg, 1);
		op(24'hc40000, 6'h00, 6'd7, CL_FAR);
		op(24'h0fb2c0, 6'h10, 6'd26, CL_FAR);
		op(24'hc50000, 6'h00, 6'd7, CL_FAR);
		op(24'hc5c000, 6'h13, 6'd26, CL_FAR);
		op(24'hc50000, 6'h13, 6'd28, CL_FAR);
		op(24'h0fb200, 6'h00, 6'd7, CL_FAR);
		op(24'h0fb200, 6'h10, 6'd28, CL_FAR);
		op(24'he60000, 6'h00, 6'd10, CL_OUT);
		op(24'he60000, 6'h1a, 6'd4, CL_OUT);
		op(24'he70000, 6'h1e, 6'd24, CL_OUT);
		op(24'ha80000, 6'h00, 6'd2, CL_TEST);
		check("test_nowrite", o_dec.writes_result, 0);
		op(24'h84c000, 6'h00, 6'd2, CL_TEST);
		check("test_rm_nowrite", o_dec.writes_result, 0);
		op(24'h3f0000, 6'h00, 6'd4, CL_ADJ);
		op(24'h270000, 6'h00, 6'd4, CL_ADJ);
		op(24'h2f0000, 6'h00, 6'd4, CL_ADJ);
		// every immediate arithmetic select on a register operand
		for (int a = 0; a < 5; a++)
		begin
			op({8'h81, 8'hc0 | 8'(ar_sel[a] << 3), 8'h00}, 6'h00, 6'd2, CL_ARITH);
			check("arith_sel", o_dec.sub_op, ar_sel[a]);
		end
		op(24'h83e800, 6'h00, 6'd2, CL_ARITH);
		check("sign_imm", o_dec.sign_imm, 1);
		op(24'h02c000, 6'h00, 6'd2, CL_ARITH);
		check("narrow", o_dec.wide, 0);
		check("to_reg", o_dec.to_reg, 1);
		op(24'h01c000, 6'h00, 6'd2, CL_ARITH);
		check("wide", o_dec.wide, 1);
		check("from_reg", o_dec.to_reg, 0);
		// memory forms: direction bit picks 7 (to memory) or 6 (to register), compare 5 or 6
		op(24'h000000, 6'h00, 6'd7, CL_ARITH);
		op(24'h030000, 6'h00, 6'd6, CL_ARITH);
		check("mem_to_reg", o_dec.to_reg, 1);
		op(24'h380000, 6'h00, 6'd5, CL_ARITH);
		check("cmp_nowrite", o_dec.writes_result, 0);
		op(24'h3b0000, 6'h00, 6'd6, CL_ARITH);
		op(24'h200000, 6'h00, 6'd7, CL_LOGIC);
		// immediate group on memory and a select outside the five arithmetic ones
		op(24'h810000, 6'h00, 6'd7, CL_ARITH);
		op(24'h813800, 6'h00, 6'd5, CL_ARITH);
		check("imm_cmp_nowrite", o_dec.writes_result, 0);
		op(24'h81c800, 6'h00, 6'd2, CL_LOGIC);
		// test forms on memory never write a result
		op(24'hf60000, 6'h00, 6'd5, CL_TEST);
		check("test_imm_nowrite", o_dec.writes_result, 0);
		op(24'h840000, 6'h00, 6'd5, CL_TEST);
		// wide shift by count on memory, a right double shift with count byte and a left one without
		op(24'hd30800, 6'h00, 6'd7, CL_SHIFT);
		check("shift_wide", o_dec.wide, 1);
		check("shift_cnt_no_imm", o_dec.has_imm8, 0);
		op(24'h0fac00, 6'h10, 6'd7, CL_DSHIFT);
		check("dbl_r_imm", o_dec.has_imm8, 1);
		op(24'h0fa5c0, 6'h00, 6'd3, CL_DSHIFT);
		check("dbl_cnt_no_imm", o_dec.has_imm8, 0);
		end_of_test();
	end
endmodule
